// File: twe_eeprom.sv
// Two-wire serial slave of an 8192 x 8 memory with write protection
`timescale 1ns/1ps
`include "twe_map.svh"

module twe_eeprom #(
	parameter int WRITE_CYCLES = `TWE_TWR_CYC
) (
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_out,
	input  wire logic wp_in,
	input  wire logic select_in_first_in,
	input  wire logic select_in_second_n_in,
	output logic      busy_out
);
	import twe_pkg::*;

	localparam int CW = $clog2(WRITE_CYCLES + 1);

	// Protected range of the array for a block setting
	function automatic logic blk_hit(input logic [1:0] bp, input logic [12:0] a);
		unique case (bp)
			`TWE_BP_NONE:  blk_hit = 1'b0;
			`TWE_BP_QUART: blk_hit = (a[12:11] == 2'h3);
			`TWE_BP_HALF:  blk_hit = a[12];
			default:       blk_hit = 1'b1;
		endcase
	endfunction : blk_hit

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] pins, s1_q, s2_q, s3_q, f_q, f_d, fp_q;
	logic       scl, sda, wp, scl_rise, scl_fall, start_det, stop_det;

	assign pins = {select_in_second_n_in, select_in_first_in, wp_in, sda_in, scl_in};

	// A change counts once stages two and three agree
	for (genvar i = 0; i < 5; i++) begin : g_filt
		assign f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
	end

	// Sync and filter registers
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_q <= `TWE_PIN_RST;
			s2_q <= `TWE_PIN_RST;
			s3_q <= `TWE_PIN_RST;
			f_q  <= `TWE_PIN_RST;
			fp_q <= `TWE_PIN_RST;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= f_d;
			fp_q <= f_q;
		end
	end

	// Edge and condition detection
	assign scl       = f_q[0];
	assign sda       = f_q[1];
	assign wp        = f_q[2];
	assign scl_rise  = scl & ~fp_q[0];
	assign scl_fall  = ~scl & fp_q[0];
	assign start_det = scl & fp_q[0] & fp_q[1] & ~sda;
	assign stop_det  = scl & fp_q[0] & ~fp_q[1] & sda;

	// ****************************************
	// Serial engine
	// ****************************************
	twe_state_t  st_q, st_d;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  sh_q, sh_d, tx_q, tx_d, wpr_dat_q, wpr_dat_d, rdat, wpr_val;
	logic [12:0] addr_q, addr_d;
	logic        nine_q, nine_d, oe_q, oe_d, first_q, first_d, mack_q, mack_d;
	logic        pend_q, pend_d, any_q, any_d, push, fifo_rdy, dev_ok;
	logic        wel_q, rwel_q, hw_protect_enable_q, busy_q;
	logic [1:0]  bp_q;
	twe_wr_t     push_dat;
	logic [7:0]  mem_q [8192];

	// Register image and read data
	always_comb begin
		wpr_val                = `TWE_WPR_RST;
		wpr_val[`TWE_HW_PROTECT_ENABLE_BIT] = hw_protect_enable_q;
		wpr_val[`TWE_BPH_BIT]  = bp_q[1];
		wpr_val[`TWE_BPL_BIT]  = bp_q[0];
		wpr_val[`TWE_RWEL_BIT] = rwel_q;
		wpr_val[`TWE_WEL_BIT]  = wel_q;
		rdat = (first_q && addr_q == `TWE_WPR_ADDR) ? wpr_val : mem_q[addr_q];
	end

	assign dev_ok   = (sh_q[7] == f_q[3]) && (sh_q[6] == ~f_q[4]) && !busy_q;
	assign push_dat = '{col: addr_q[4:0], data: sh_q};

	// Next state of the serial engine
	always_comb begin
		st_d = st_q; bit_d = bit_q; nine_d = nine_q; sh_d = sh_q; tx_d = tx_q;
		oe_d = oe_q; addr_d = addr_q; first_d = first_q; mack_d = mack_q;
		pend_d = pend_q; wpr_dat_d = wpr_dat_q; any_d = any_q; push = 1'b0;
		if (start_det) begin
			st_d = ST_DEV; bit_d = 4'h0; nine_d = 1'b0; oe_d = 1'b0; first_d = 1'b1;
		end else if (stop_det) begin
			st_d = ST_IDLE; bit_d = 4'h0; nine_d = 1'b0; oe_d = 1'b0;
			pend_d = 1'b0; any_d = 1'b0;
		end else if (st_q != ST_IDLE) begin
			if (scl_rise) begin
				if (nine_q) begin
					mack_d = ~sda;
				end else begin
					sh_d  = {sh_q[6:0], sda};
					bit_d = bit_q + 4'h1;
				end
			end else if (scl_fall) begin
				if (nine_q) begin
					nine_d = 1'b0; bit_d = 4'h0; oe_d = 1'b0;
					if (st_q == ST_READ) begin
						if (mack_q) begin
							tx_d = rdat; oe_d = ~rdat[7];
						end else begin
							st_d = ST_IDLE;
						end
					end
				end else if (bit_q == `TWE_BYTE_BITS) begin
					nine_d = 1'b1;
					unique case (st_q)
						ST_DEV: begin
							if (dev_ok) begin
								oe_d = 1'b1;
								addr_d[12:8] = sh_q[5:1];
								mack_d = sh_q[0];
								st_d = sh_q[0] ? ST_READ : ST_ADDR;
							end else begin
								st_d = ST_IDLE;
							end
						end
						ST_ADDR: begin
							addr_d[7:0] = sh_q; oe_d = 1'b1; st_d = ST_WDATA;
						end
						ST_WDATA: begin
							first_d = 1'b0;
							if (first_q && addr_q == `TWE_WPR_ADDR) begin
								pend_d = 1'b1; wpr_dat_d = sh_q; oe_d = 1'b1;
							end else if (!wel_q || !fifo_rdy) begin
								oe_d = 1'b0;
							end else begin
								push = 1'b1; any_d = 1'b1; oe_d = 1'b1;
								addr_d[4:0] = addr_q[4:0] + 5'h01;
							end
						end
						ST_READ: begin
							oe_d = 1'b0; first_d = 1'b0;
							addr_d = addr_q + 13'h0001;
						end
						default: st_d = ST_IDLE;
					endcase
				end else if (st_q == ST_READ && bit_q != 4'h0) begin
					tx_d = {tx_q[6:0], 1'b0}; oe_d = ~tx_q[6];
				end
			end
		end
	end

	// Serial engine registers
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= ST_IDLE; bit_q <= 4'h0; nine_q <= 1'b0; sh_q <= 8'h00;
			tx_q <= 8'h00; oe_q <= 1'b0; addr_q <= 13'h0000; first_q <= 1'b0;
			mack_q <= 1'b0; pend_q <= 1'b0; wpr_dat_q <= 8'h00; any_q <= 1'b0;
		end else begin
			st_q <= st_d; bit_q <= bit_d; nine_q <= nine_d; sh_q <= sh_d;
			tx_q <= tx_d; oe_q <= oe_d; addr_q <= addr_d; first_q <= first_d;
			mack_q <= mack_d; pend_q <= pend_d; wpr_dat_q <= wpr_dat_d; any_q <= any_d;
		end
	end

	assign sda_out    = 1'b0;
	assign sda_oe_out = oe_q;

	// ****************************************
	// Page buffer, protection and write cycle
	// ****************************************
	logic          f_valid, wel_d, rwel_d, hw_protect_enable_d, busy_d, wr_en, hw_lock;
	logic [1:0]    bp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [7:0]    hi_q, hi_d;
	logic [31:0]   mask_q, mask_d;
	logic [7:0]    page_q [32];
	logic [7:0]    page_d [32];
	logic [12:0]   wr_addr;
	twe_wr_t       f_dat;

	twe_fifo2 u_buf (
		.clock_in      (clock_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (push),
		.in_data_in    (push_dat),
		.in_ready_out  (fifo_rdy),
		.out_valid_out (f_valid),
		.out_data_out  (f_dat),
		.out_ready_in  (~busy_q)
	);

	assign hw_lock = wp & hw_protect_enable_q;
	assign wr_addr = {hi_q, cnt_q[4:0]};

	// Next protect bits, page contents and cycle timer
	always_comb begin
		wel_d = wel_q; rwel_d = rwel_q; bp_d = bp_q; hw_protect_enable_d = hw_protect_enable_q;
		busy_d = busy_q; cnt_d = cnt_q; hi_d = hi_q; mask_d = mask_q; page_d = page_q;
		wr_en = 1'b0;
		if (push) begin
			hi_d = addr_q[12:5];
		end
		if (busy_q) begin
			cnt_d = cnt_q + CW'(1);
			if (cnt_q < CW'(`TWE_PAGE_LEN)) begin
				wr_en = mask_q[cnt_q[4:0]] & wel_q & ~blk_hit(bp_q, wr_addr);
			end
			if (cnt_q == CW'(WRITE_CYCLES - 1)) begin
				busy_d = 1'b0; mask_d = 32'h00000000;
			end
		end else begin
			if (f_valid) begin
				page_d[f_dat.col] = f_dat.data;
				mask_d[f_dat.col] = 1'b1;
			end
			if (stop_det && any_q) begin
				busy_d = 1'b1; cnt_d = '0;
			end else if (stop_det && pend_q) begin
				if (!wpr_dat_q[`TWE_WEL_BIT]) begin
					wel_d = 1'b0; rwel_d = 1'b0;
				end else if (wpr_dat_q[`TWE_RWEL_BIT]) begin
					rwel_d = wel_q | rwel_q;
				end else if (rwel_q) begin
					rwel_d = 1'b0;
					if (!hw_lock) begin
						bp_d = wpr_dat_q[`TWE_BPH_BIT:`TWE_BPL_BIT];
						hw_protect_enable_d = wpr_dat_q[`TWE_HW_PROTECT_ENABLE_BIT];
						busy_d = 1'b1; cnt_d = '0;
					end
				end else begin
					wel_d = 1'b1;
				end
			end
		end
	end

	// Protect, page and timer registers
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wel_q <= 1'b0; rwel_q <= 1'b0; busy_q <= 1'b0; cnt_q <= '0;
			bp_q <= 2'(`TWE_WPR_RST >> `TWE_BPL_BIT); hw_protect_enable_q <= 1'b0;
			hi_q <= 8'h00; mask_q <= 32'h00000000; page_q <= '{default: 8'h00};
		end else begin
			wel_q <= wel_d; rwel_q <= rwel_d; busy_q <= busy_d; cnt_q <= cnt_d;
			bp_q <= bp_d; hw_protect_enable_q <= hw_protect_enable_d;
			hi_q <= hi_d; mask_q <= mask_d; page_q <= page_d;
		end
	end

	// Array storage, one byte committed per cycle
	always_ff @(posedge clock_in) begin
		if (wr_en) begin
			mem_q[wr_addr] <= page_q[cnt_q[4:0]];
		end
	end

	assign busy_out = busy_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_cycle_go;
		!busy_q ##1 busy_q;
	endsequence
	sequence s_dev_byte;
		st_q == ST_DEV && scl_fall && bit_q == `TWE_BYTE_BITS && !nine_q;
	endsequence

	AST_OE_CLK_LOW: assert property ($rose(oe_q) |-> !scl)
		else $error("data driven while clock high");
	AST_START_ARMS: assert property (start_det |=> st_q == ST_DEV && !oe_q && bit_q == 4'h0)
		else $error("start not taken");
	AST_STOP_IDLE: assert property (stop_det |=> st_q == ST_IDLE && !oe_q)
		else $error("stop did not end transaction");
	AST_BUSY_NACK: assert property (s_dev_byte and busy_q |=> !oe_q ##1 !oe_q)
		else $error("address acknowledged while busy");
	AST_MISMATCH: assert property (s_dev_byte and (sh_q[7] != f_q[3]) |=> st_q == ST_IDLE && !oe_q)
		else $error("foreign address acknowledged");
	AST_WEL_NACK: assert property (st_q == ST_WDATA && scl_fall && bit_q == `TWE_BYTE_BITS
		&& !nine_q && !wel_q && addr_q != `TWE_WPR_ADDR |=> !oe_q && !push)
		else $error("write acknowledged with latch clear");
	AST_PAGE_WRAP: assert property (push |=> addr_q[12:5] == $past(addr_q[12:5])
		&& addr_q[4:0] == 5'($past(addr_q[4:0]) + 5'h01))
		else $error("page address did not wrap");
	AST_CYCLE_HOLD: assert property (s_cycle_go |-> busy_q[*8])
		else $error("write cycle ended early");
	AST_PROT_WRITE: assert property (wr_en |-> wel_q && !blk_hit(bp_q, wr_addr))
		else $error("protected byte written");
	AST_LOCKED_REG: assert property (hw_lock && !busy_q |=> bp_q == $past(bp_q))
		else $error("locked block bits changed");

endmodule : twe_eeprom

// File: twe_fifo2.sv
// Two-entry buffer between the serial engine and the page buffer
`timescale 1ns/1ps
module twe_fifo2 (
	input  wire logic            clock_in,
	input  wire logic            sys_rst_in,
	input  wire logic            in_valid_in,
	input  wire twe_pkg::twe_wr_t in_data_in,
	output logic                 in_ready_out,
	output logic                 out_valid_out,
	output twe_pkg::twe_wr_t     out_data_out,
	input  wire logic            out_ready_in
);
	import twe_pkg::*;

	twe_wr_t    slot_q [2];
	twe_wr_t    slot_d [2];
	logic       wp_q, wp_d, rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic       push, pop;

	// Handshakes straight from the fill count
	assign in_ready_out  = (cnt_q != 2'h2);
	assign out_valid_out = (cnt_q != 2'h0);
	assign out_data_out  = slot_q[rp_q];

	// Next pointers, count and slots
	always_comb begin
		push   = in_valid_in & in_ready_out;
		pop    = out_valid_out & out_ready_in;
		slot_d = slot_q;
		wp_d   = wp_q ^ push;
		rp_d   = rp_q ^ pop;
		cnt_d  = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		if (push) begin
			slot_d[wp_q] = in_data_in;
		end
	end

	// Register stage
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			slot_q <= '{default: '0};
			wp_q   <= 1'b0;
			rp_q   <= 1'b0;
			cnt_q  <= 2'h0;
		end else begin
			slot_q <= slot_d;
			wp_q   <= wp_d;
			rp_q   <= rp_d;
			cnt_q  <= cnt_d;
		end
	end

endmodule : twe_fifo2

// File: twe_map.svh
// Address, field and timing constants of the two-wire memory slave
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH

// ****************************************
// Protect register
// ****************************************
`define TWE_WPR_ADDR   13'h1fff
`define TWE_WPR_RST    8'h00
`define TWE_HW_PROTECT_ENABLE_BIT   7
`define TWE_BPH_BIT    4
`define TWE_BPL_BIT    3
`define TWE_RWEL_BIT   2
`define TWE_WEL_BIT    1
`define TWE_BP_NONE    2'h0
`define TWE_BP_QUART   2'h1
`define TWE_BP_HALF    2'h2

// ****************************************
// Serial framing and timing
// ****************************************
`define TWE_BYTE_BITS  4'h8
`define TWE_PAGE_LEN   32
`define TWE_PIN_RST    5'h03
`define TWE_CLK_MHZ    25
`define TWE_TWR_US     5000
`define TWE_TWR_CYC    (`TWE_TWR_US * `TWE_CLK_MHZ)

`endif

// File: twe_master.sv
// Behavioural two-wire bus master facing the memory slave
`timescale 1ns/1ps
module twe_master (
	input  wire logic clock_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_m_out
);
	// Idle bus: clock stands high, data released to pull-up
	initial begin
		scl_out = 1'b1;
		sda_m_out = 1'b1;
	end
	// Wait system clocks, stepping on the falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask : tick
	// One bit slot, low five clocks and high three; the long low phase
	// lets the slave's pin sync see the fall and turn its driver in time
	task automatic slot(input logic bv, output logic s);
		tick(2);
		sda_m_out = bv;
		tick(3);
		scl_out = 1'b1;
		tick(2);
		s = sda_in;
		tick(1);
		scl_out = 1'b0;
	endtask : slot
	// Start or repeated start, ends with clock low
	task automatic start();
		tick(2);
		sda_m_out = 1'b1;
		tick(3);
		scl_out = 1'b1;
		tick(4);
		sda_m_out = 1'b0;
		tick(4);
		scl_out = 1'b0;
	endtask : start
	// Stop after the other party has let go of data
	task automatic stop();
		tick(2);
		sda_m_out = 1'b0;
		tick(3);
		scl_out = 1'b1;
		tick(4);
		sda_m_out = 1'b1;
		tick(8);
	endtask : stop
	// Send a byte, data released in the ninth slot
	task automatic tx(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], s);
		end
		slot(1'b1, s);
		ack = ~s;
	endtask : tx
	// Receive a byte, then acknowledge or withhold it
	task automatic rx(output logic [7:0] d, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, d[i]);
		end
		slot(~ack, s);
	endtask : rx
endmodule : twe_master

// File: twe_pkg.sv
// Types shared by the two-wire memory slave
package twe_pkg;

	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADDR,
		ST_WDATA,
		ST_READ
	} twe_state_t;

	// One received byte bound for the page buffer
	typedef struct packed {
		logic [4:0] col;
		logic [7:0] data;
	} twe_wr_t;

endpackage : twe_pkg

// File: two_wire_eeprom_slave_write_protect_test.sv
// Self-checking bench of the two-wire memory slave
`timescale 1ns/1ps
module two_wire_eeprom_slave_write_protect_test;
	localparam int WC = 200;
	logic       clk, rst, wp, sel1, sel2_n, scl, sda_m, sda_out, sda_oe, busy, sda, k;
	logic [7:0] b;
	int         fail_count, n_compared, cyc, run, last_len;

	twe_eeprom #(.WRITE_CYCLES(WC)) uut (.clock_in(clk), .sys_rst_in(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe), .wp_in(wp),
		.select_in_first_in(sel1), .select_in_second_n_in(sel2_n), .busy_out(busy));
	twe_master m (.clock_in(clk), .sda_in(sda), .scl_out(scl), .sda_m_out(sda_m));
	// Open-drain data wire with pull-up
	assign sda = sda_oe ? sda_out : sda_m;

	// System clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Busy length monitor and hang guard
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (busy === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_len <= run;
			run <= 0;
		end
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Address byte for select pins 1 and 0
	function automatic logic [7:0] devb(input logic [12:0] a, input logic rw);
		return {2'b11, a[12:8], rw};
	endfunction : devb

	task automatic wr(input logic [12:0] a, input logic [7:0] d[$], input logic ea);
		m.start();
		m.tx(devb(a, 1'b0), k);
		chk("dev ack", 1, k);
		m.tx(a[7:0], k);
		chk("addr ack", 1, k);
		foreach (d[i]) begin
			m.tx(d[i], k);
			chk("data ack", ea, k);
		end
		m.stop();
	endtask : wr

	task automatic rd(input logic [12:0] a, input logic [7:0] e[$]);
		m.start();
		m.tx(devb(a, 1'b0), k);
		m.tx(a[7:0], k);
		m.start();
		m.tx(devb(a, 1'b1), k);
		chk("read ack", 1, k);
		foreach (e[i]) begin
			m.rx(b, i < e.size() - 1);
			chk("read data", e[i], b);
		end
		m.stop();
	endtask : rd

	task automatic poll(input logic ea);
		m.start();
		m.tx(devb(13'h0000, 1'b0), k);
		chk("poll ack", ea, k);
		m.stop();
	endtask : poll

	task automatic done(input logic lc);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("busy clear", 0, busy);
		@(negedge clk);
		if (lc) begin
			chk("busy length", WC, last_len);
		end
	endtask : done

	// Main sequence
	initial begin
		fail_count = 0;
		n_compared = 0;
		cyc = 0;
		run = 0;
		last_len = 0;
		rst = 1'b1;
		wp = 1'b0;
		sel1 = 1'b1;
		sel2_n = 1'b0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		wr(13'h0100, '{8'h11}, 1'b0);
		for (int j = 0; j < 3; j++) begin
			m.start();
			m.tx({j[1:0], 6'h00}, k);
			chk("select ack", 0, k);
			m.stop();
		end
		wr(13'h1fff, '{8'h02}, 1'b1);
		rd(13'h1fff, '{8'h02});
		wr(13'h1800, '{8'h5a}, 1'b1);
		chk("busy", 1, busy);
		done(1'b1);
		wr(13'h0a1e, '{8'ha1, 8'ha2, 8'ha3}, 1'b1);
		poll(1'b0);
		done(1'b1);
		poll(1'b1);
		rd(13'h0a1e, '{8'ha1, 8'ha2});
		rd(13'h0a00, '{8'ha3});
		wr(13'h1fff, '{8'h06}, 1'b1);
		wr(13'h1fff, '{8'h0a}, 1'b1);
		done(1'b1);
		rd(13'h1fff, '{8'h0a});
		wr(13'h1800, '{8'hc3}, 1'b1);
		done(1'b0);
		rd(13'h1800, '{8'h5a});
		wp = 1'b1;
		wr(13'h17ff, '{8'h3c}, 1'b1);
		done(1'b1);
		rd(13'h17ff, '{8'h3c});
		wr(13'h1fff, '{8'h06}, 1'b1);
		wr(13'h1fff, '{8'h8a}, 1'b1);
		done(1'b1);
		wr(13'h1fff, '{8'h06}, 1'b1);
		wr(13'h1fff, '{8'h12}, 1'b1);
		chk("locked busy", 0, busy);
		rd(13'h1fff, '{8'h8a});
		print_verdict();
	end
endmodule : two_wire_eeprom_slave_write_protect_test
